// [verilog/rcs_pkg.sv]
// Shared constants, types and legality functions for the reset configuration straps block.
// Operation
// [RL1] Strap picks vector base 0x00000000 or 0xFFFF0000; field loads from it.
// [RL2] Strap sets reset value of the exception byte order field.
// [RL3] Strap sets reset value of the exception instruction state field.
// [RL4] Strap enables secondary RAM at reset; base is zero or configured value.
// [RL5] A local RAM is enabled only when its port exists in the build.
// [RL6] Strap makes the fast interrupt non-maskable; then software cannot mask it.
// [RL7] Strap selects odd or even parity for all parity generation and checking.
// [RL8] Secondary RAM parity check enables are two independent per-bank controls.
// [RL9] With ECC, both secondary banks' checks are enabled together by one control.
// [RL10] Check enables set only with matching scheme and number of ports built.
// [RL11] External error enables per RAM and bank, strap reset value, independent.
// [RL12] Read-modify-write enables from straps, allowed only without 32-bit ECC.
// [RL13] Every strap-set feature is writable by software once reset has ended; here parity type and the non-maskable fast interrupt have no software write.
// [RL14] Strap enables primary RAM at reset; base is zero or configured value.
// [RL15] Straps are captured at reset release; later strap changes do nothing.
// [RL16] Integrator holds straps static through reset, unused options tied disabled.
package rcs_pkg;

	// Error checking scheme a local RAM is built with.
	typedef enum logic [1:0] {
		RCS_CHK_NONE,
		RCS_CHK_PARITY,
		RCS_CHK_ECC32,
		RCS_CHK_ECC64
	} rcs_check_t;

	// Exception vector table bases.
	localparam logic [31:0] RCS_VEC_LOW_BASE  = 32'h0000_0000;
	localparam logic [31:0] RCS_VEC_HIGH_BASE = 32'hffff_0000;

	// Local RAM base used when the configured base is not selected.
	localparam logic [31:0] RCS_RAM_BASE_ZERO = 32'h0000_0000;

	// Reset values of the held fields before the straps are taken.
	localparam logic        RCS_FIELD_RST    = 1'b0;
	localparam logic        RCS_FIQ_MASK_RST = 1'b1;
	localparam logic        RCS_PEND_RST     = 1'b1;

	// Width of the packed strap vector watched for movement.
	localparam int          RCS_STRAP_W = 17;

	// True when the RAM has a check scheme and the port is present.
	function automatic logic rcs_check_ok(input rcs_check_t scheme, input logic port_ok);
		return (scheme != RCS_CHK_NONE) && port_ok;
	endfunction

	// True when the scheme is one of the ECC variants.
	function automatic logic rcs_is_ecc(input rcs_check_t scheme);
		return (scheme == RCS_CHK_ECC32) || (scheme == RCS_CHK_ECC64);
	endfunction

	// Read-modify-write needs the port and no 32-bit ECC.
	function automatic logic rcs_rmw_ok(input rcs_check_t scheme, input logic port_ok);
		return port_ok && (scheme != RCS_CHK_ECC32);
	endfunction

endpackage

// [verilog/rcs_strap_capture.sv]
// Release-edge strap capture with a load pulse and a strap movement monitor.
`timescale 1ns/1ns

module rcs_strap_capture #(
	parameter int W = 17
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] straps,
	output logic              load,
	output logic              loaded,
	output logic              moved
);

	logic         pend_q;
	logic         pend_d;
	logic [W-1:0] snap_q;
	logic [W-1:0] snap_d;
	logic         moved_q;
	logic         moved_d;

	// The flops take only constants under reset; the straps are caught on the first edge after.
	always_comb begin
		pend_d  = 1'b0;
		snap_d  = pend_q ? straps : snap_q; // see [RL15]
		moved_d = moved_q | (~pend_q & (straps != snap_q)); // see [RL16]
	end

	// Registers of the capture stage.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pend_q  <= rcs_pkg::RCS_PEND_RST;
			snap_q  <= '0;
			moved_q <= 1'b0;
		end else begin
			pend_q  <= pend_d;
			snap_q  <= snap_d;
			moved_q <= moved_d;
		end
	end

	// The pulse is the pending flag itself, so it is high through reset and for exactly one cycle after release.
	assign load   = pend_q;
	assign loaded = ~pend_q;
	assign moved  = moved_q;

	// The release edge still samples the pulse high, so the sampled reset keeps that edge out.
	a_load_single: assert property (@(posedge core_clk) disable iff (rst)
		!rst && load |=> !load[*3]) // see [RL15]
		else $error("strap load pulse repeated");

endmodule

// [verilog/rcs_top.sv]
// Reset configuration straps: held control fields loaded at release and written by software.
`timescale 1ns/1ns

module rcs_top #(
	parameter int unsigned        PRIMARY_PORTS    = 1,
	parameter int unsigned        SECONDARY_PORTS  = 2,
	parameter rcs_pkg::rcs_check_t PRIMARY_CHECK   = rcs_pkg::RCS_CHK_PARITY,
	parameter rcs_pkg::rcs_check_t SECONDARY_CHECK = rcs_pkg::RCS_CHK_PARITY,
	parameter logic [31:0]        PRIMARY_CFG_BASE   = 32'h0000_0000,
	parameter logic [31:0]        SECONDARY_CFG_BASE = 32'h0000_0000,
	parameter logic               BUS_PARITY       = 1'b0
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        cfg_vec_high,
	input  wire logic        cfg_byte_order,
	input  wire logic        cfg_instr_state,
	input  wire logic        cfg_primary_en,
	input  wire logic        cfg_primary_base_sel,
	input  wire logic        cfg_secondary_en,
	input  wire logic        cfg_secondary_base_sel,
	input  wire logic        cfg_fiq_nonmaskable,
	input  wire logic        cfg_parity_odd,
	input  wire logic        cfg_primary_check,
	input  wire logic        cfg_bank0_check,
	input  wire logic        cfg_bank1_check,
	input  wire logic        cfg_primary_ext_err,
	input  wire logic        cfg_bank0_ext_err,
	input  wire logic        cfg_bank1_ext_err,
	input  wire logic        cfg_primary_rmw,
	input  wire logic        cfg_secondary_rmw,
	input  wire logic        sw_sys_wr,
	input  wire logic        sw_vec_high,
	input  wire logic        sw_byte_order,
	input  wire logic        sw_instr_state,
	input  wire logic        sw_fiq_mask,
	input  wire logic        sw_region_wr,
	input  wire logic        sw_primary_en,
	input  wire logic [31:0] sw_primary_base,
	input  wire logic        sw_secondary_en,
	input  wire logic [31:0] sw_secondary_base,
	input  wire logic        sw_aux_wr,
	input  wire logic        sw_primary_check_en,
	input  wire logic        sw_bank0_check_en,
	input  wire logic        sw_bank1_check_en,
	input  wire logic        sw_primary_ext_err_en,
	input  wire logic        sw_bank0_ext_err_en,
	input  wire logic        sw_bank1_ext_err_en,
	input  wire logic        sw_primary_rmw_en,
	input  wire logic        sw_secondary_rmw_en,
	output logic [31:0]      vector_base,
	output logic             exception_byte_order,
	output logic             exception_instr_state,
	output logic             primary_local_ram_en,
	output logic [31:0]      primary_local_ram_base,
	output logic             secondary_local_ram_en,
	output logic [31:0]      secondary_local_ram_base,
	output logic             fast_interrupt_nonmaskable,
	output logic             fast_interrupt_masked,
	output logic             parity_odd,
	output logic             parity_in_use,
	output logic             primary_ram_check_en,
	output logic             secondary_bank0_check_en,
	output logic             secondary_bank1_check_en,
	output logic             primary_ram_ext_err_en,
	output logic             secondary_bank0_ext_err_en,
	output logic             secondary_bank1_ext_err_en,
	output logic             primary_ram_rmw_en,
	output logic             secondary_ram_rmw_en,
	output logic             cfg_loaded,
	output logic             cfg_strap_moved
);

	// Build-time legality of each control, fixed by the parameters.
	localparam logic PRIM_OK     = (PRIMARY_PORTS >= 1);
	localparam logic BANK0_OK    = (SECONDARY_PORTS >= 1);
	localparam logic BANK1_OK    = (SECONDARY_PORTS >= 2);
	localparam logic PRIM_CHK_OK = rcs_pkg::rcs_check_ok(PRIMARY_CHECK, PRIM_OK);
	localparam logic B0_CHK_OK   = rcs_pkg::rcs_check_ok(SECONDARY_CHECK, BANK0_OK);
	localparam logic B1_CHK_OK   = rcs_pkg::rcs_check_ok(SECONDARY_CHECK, BANK1_OK);
	localparam logic SEC_ECC     = rcs_pkg::rcs_is_ecc(SECONDARY_CHECK);
	localparam logic PRIM_RMW_OK = rcs_pkg::rcs_rmw_ok(PRIMARY_CHECK, PRIM_OK);
	localparam logic SEC_RMW_OK  = rcs_pkg::rcs_rmw_ok(SECONDARY_CHECK, BANK0_OK);

	logic        load;
	logic [31:0] vec_base_q, vec_base_d;
	logic        byte_order_q, byte_order_d;
	logic        instr_state_q, instr_state_d;
	logic        prim_en_q, prim_en_d;
	logic [31:0] prim_base_q, prim_base_d;
	logic        sec_en_q, sec_en_d;
	logic [31:0] sec_base_q, sec_base_d;
	logic        nmfi_q, nmfi_d;
	logic        fiq_mask_q, fiq_mask_d;
	logic        par_odd_q, par_odd_d;
	logic        prim_chk_q, prim_chk_d;
	logic        b0_chk_q, b0_chk_d;
	logic        b1_chk_q, b1_chk_d;
	logic        prim_ext_q, prim_ext_d;
	logic        b0_ext_q, b0_ext_d;
	logic        b1_ext_q, b1_ext_d;
	logic        prim_rmw_q, prim_rmw_d;
	logic        sec_rmw_q, sec_rmw_d;

	// The straps are held by the integrator; the capture stage times the load pulse and flags a later change.
	rcs_strap_capture #(
		.W (rcs_pkg::RCS_STRAP_W)
	) u_capture (
		.core_clk (core_clk),
		.rst      (rst),
		.straps   ({cfg_vec_high, cfg_byte_order, cfg_instr_state, cfg_primary_en,
			cfg_primary_base_sel, cfg_secondary_en, cfg_secondary_base_sel,
			cfg_fiq_nonmaskable, cfg_parity_odd, cfg_primary_check, cfg_bank0_check,
			cfg_bank1_check, cfg_primary_ext_err, cfg_bank0_ext_err, cfg_bank1_ext_err,
			cfg_primary_rmw, cfg_secondary_rmw}),
		.load     (load),
		.loaded   (cfg_loaded),
		.moved    (cfg_strap_moved)
	);

	// Next values: the release load wins over software, whose writes are ignored in that cycle.
	always_comb begin
		vec_base_d    = vec_base_q;
		byte_order_d  = byte_order_q;
		instr_state_d = instr_state_q;
		prim_en_d     = prim_en_q;
		prim_base_d   = prim_base_q;
		sec_en_d      = sec_en_q;
		sec_base_d    = sec_base_q;
		nmfi_d        = nmfi_q;
		fiq_mask_d    = fiq_mask_q;
		par_odd_d     = par_odd_q;
		prim_chk_d    = prim_chk_q;
		b0_chk_d      = b0_chk_q;
		b1_chk_d      = b1_chk_q;
		prim_ext_d    = prim_ext_q;
		b0_ext_d      = b0_ext_q;
		b1_ext_d      = b1_ext_q;
		prim_rmw_d    = prim_rmw_q;
		sec_rmw_d     = sec_rmw_q;
		if (load) begin
			vec_base_d    = cfg_vec_high ? rcs_pkg::RCS_VEC_HIGH_BASE
				: rcs_pkg::RCS_VEC_LOW_BASE; // see [RL1] see [RL15]
			byte_order_d  = cfg_byte_order; // see [RL2]
			instr_state_d = cfg_instr_state; // see [RL3]
			prim_en_d     = cfg_primary_en & PRIM_OK; // see [RL14] see [RL5]
			prim_base_d   = cfg_primary_base_sel ? PRIMARY_CFG_BASE
				: rcs_pkg::RCS_RAM_BASE_ZERO; // see [RL14]
			sec_en_d      = cfg_secondary_en & BANK0_OK; // see [RL4] see [RL5]
			sec_base_d    = cfg_secondary_base_sel ? SECONDARY_CFG_BASE
				: rcs_pkg::RCS_RAM_BASE_ZERO; // see [RL4]
			nmfi_d        = cfg_fiq_nonmaskable; // see [RL6]
			fiq_mask_d    = ~cfg_fiq_nonmaskable; // see [RL6]
			par_odd_d     = cfg_parity_odd; // see [RL7]
			prim_chk_d    = cfg_primary_check & PRIM_CHK_OK; // see [RL10]
			b0_chk_d      = cfg_bank0_check & B0_CHK_OK; // see [RL8]
			b1_chk_d      = (SEC_ECC ? cfg_bank0_check : cfg_bank1_check) & B1_CHK_OK; // see [RL9]
			prim_ext_d    = cfg_primary_ext_err & PRIM_OK; // see [RL11]
			b0_ext_d      = cfg_bank0_ext_err & BANK0_OK; // see [RL11]
			b1_ext_d      = cfg_bank1_ext_err & BANK1_OK; // see [RL11]
			prim_rmw_d    = cfg_primary_rmw & PRIM_RMW_OK; // see [RL12]
			sec_rmw_d     = cfg_secondary_rmw & SEC_RMW_OK; // see [RL12]
		end else begin
			if (sw_sys_wr) begin
				vec_base_d    = sw_vec_high ? rcs_pkg::RCS_VEC_HIGH_BASE
					: rcs_pkg::RCS_VEC_LOW_BASE; // see [RL13]
				byte_order_d  = sw_byte_order; // see [RL13]
				instr_state_d = sw_instr_state; // see [RL13]
				fiq_mask_d    = sw_fiq_mask & ~nmfi_q; // see [RL6]
			end
			if (sw_region_wr) begin
				prim_en_d   = sw_primary_en & PRIM_OK; // see [RL13] see [RL5]
				prim_base_d = sw_primary_base; // see [RL13]
				sec_en_d    = sw_secondary_en & BANK0_OK; // see [RL13] see [RL5]
				sec_base_d  = sw_secondary_base; // see [RL13]
			end
			if (sw_aux_wr) begin
				prim_chk_d = sw_primary_check_en & PRIM_CHK_OK; // see [RL10] see [RL13]
				b0_chk_d   = sw_bank0_check_en & B0_CHK_OK; // see [RL8]
				// ECC has one control for both banks, so bank 1 follows the bank 0 bit.
				b1_chk_d   = (SEC_ECC ? sw_bank0_check_en : sw_bank1_check_en)
					& B1_CHK_OK; // see [RL9] see [RL8]
				prim_ext_d = sw_primary_ext_err_en & PRIM_OK; // see [RL11]
				b0_ext_d   = sw_bank0_ext_err_en & BANK0_OK; // see [RL11]
				b1_ext_d   = sw_bank1_ext_err_en & BANK1_OK; // see [RL11]
				prim_rmw_d = sw_primary_rmw_en & PRIM_RMW_OK; // see [RL12]
				sec_rmw_d  = sw_secondary_rmw_en & SEC_RMW_OK; // see [RL12]
			end
		end
	end

	// Field registers; only constants under reset, the straps arrive through the load path.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			vec_base_q    <= rcs_pkg::RCS_VEC_LOW_BASE;
			byte_order_q  <= rcs_pkg::RCS_FIELD_RST;
			instr_state_q <= rcs_pkg::RCS_FIELD_RST;
			prim_en_q     <= rcs_pkg::RCS_FIELD_RST;
			prim_base_q   <= rcs_pkg::RCS_RAM_BASE_ZERO;
			sec_en_q      <= rcs_pkg::RCS_FIELD_RST;
			sec_base_q    <= rcs_pkg::RCS_RAM_BASE_ZERO;
			nmfi_q        <= rcs_pkg::RCS_FIELD_RST;
			fiq_mask_q    <= rcs_pkg::RCS_FIQ_MASK_RST;
			par_odd_q     <= rcs_pkg::RCS_FIELD_RST;
			prim_chk_q    <= rcs_pkg::RCS_FIELD_RST;
			b0_chk_q      <= rcs_pkg::RCS_FIELD_RST;
			b1_chk_q      <= rcs_pkg::RCS_FIELD_RST;
			prim_ext_q    <= rcs_pkg::RCS_FIELD_RST;
			b0_ext_q      <= rcs_pkg::RCS_FIELD_RST;
			b1_ext_q      <= rcs_pkg::RCS_FIELD_RST;
			prim_rmw_q    <= rcs_pkg::RCS_FIELD_RST;
			sec_rmw_q     <= rcs_pkg::RCS_FIELD_RST;
		end else begin
			vec_base_q    <= vec_base_d;
			byte_order_q  <= byte_order_d;
			instr_state_q <= instr_state_d;
			prim_en_q     <= prim_en_d;
			prim_base_q   <= prim_base_d;
			sec_en_q      <= sec_en_d;
			sec_base_q    <= sec_base_d;
			nmfi_q        <= nmfi_d;
			fiq_mask_q    <= fiq_mask_d;
			par_odd_q     <= par_odd_d;
			prim_chk_q    <= prim_chk_d;
			b0_chk_q      <= b0_chk_d;
			b1_chk_q      <= b1_chk_d;
			prim_ext_q    <= prim_ext_d;
			b0_ext_q      <= b0_ext_d;
			b1_ext_q      <= b1_ext_d;
			prim_rmw_q    <= prim_rmw_d;
			sec_rmw_q     <= sec_rmw_d;
		end
	end

	// Outputs straight from the field registers.
	assign vector_base                = vec_base_q;
	assign exception_byte_order       = byte_order_q;
	assign exception_instr_state      = instr_state_q;
	assign primary_local_ram_en       = prim_en_q;
	assign primary_local_ram_base     = prim_base_q;
	assign secondary_local_ram_en     = sec_en_q;
	assign secondary_local_ram_base   = sec_base_q;
	assign fast_interrupt_nonmaskable = nmfi_q;
	assign fast_interrupt_masked      = fiq_mask_q;
	assign parity_odd                 = par_odd_q;
	assign primary_ram_check_en       = prim_chk_q;
	assign secondary_bank0_check_en   = b0_chk_q;
	assign secondary_bank1_check_en   = b1_chk_q;
	assign primary_ram_ext_err_en     = prim_ext_q;
	assign secondary_bank0_ext_err_en = b0_ext_q;
	assign secondary_bank1_ext_err_en = b1_ext_q;
	assign primary_ram_rmw_en         = prim_rmw_q;
	assign secondary_ram_rmw_en       = sec_rmw_q;

	// The parity type only matters when some parity logic is built; this is a build constant.
	assign parity_in_use = (PRIMARY_CHECK == rcs_pkg::RCS_CHK_PARITY)
		| (SECONDARY_CHECK == rcs_pkg::RCS_CHK_PARITY) | BUS_PARITY; // see [RL7]

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_vec_base_load: assert property ( // see [RL1]
		!rst && load |=> vector_base == ($past(cfg_vec_high) ? rcs_pkg::RCS_VEC_HIGH_BASE
			: rcs_pkg::RCS_VEC_LOW_BASE))
		else $error("vector base not loaded from strap");

	a_byte_order_load: assert property ( // see [RL2]
		!rst && load |=> exception_byte_order == $past(cfg_byte_order))
		else $error("byte order not loaded from strap");

	a_instr_state_load: assert property ( // see [RL3]
		!rst && load |=> exception_instr_state == $past(cfg_instr_state))
		else $error("instruction state not loaded from strap");

	a_secondary_base_load: assert property ( // see [RL4]
		!rst && load |=> secondary_local_ram_base == ($past(cfg_secondary_base_sel)
			? SECONDARY_CFG_BASE : rcs_pkg::RCS_RAM_BASE_ZERO))
		else $error("secondary base wrong after load");

	a_ram_port_gate: assert property ( // see [RL5]
		(!BANK0_OK |-> !secondary_local_ram_en) and (!PRIM_OK |-> !primary_local_ram_en))
		else $error("local RAM enabled without a port");

	a_fiq_mask_block: assert property ( // see [RL6]
		fast_interrupt_nonmaskable && cfg_loaded |-> !fast_interrupt_masked)
		else $error("non-maskable fast interrupt was masked");

	a_parity_held: assert property ( // see [RL7]
		cfg_loaded |=> $stable(parity_odd))
		else $error("parity type changed after load");

	a_bank_split: assert property ( // see [RL8]
		sw_aux_wr && cfg_loaded && !SEC_ECC && B1_CHK_OK
			|=> secondary_bank1_check_en == $past(sw_bank1_check_en)
			&& secondary_bank0_check_en == $past(sw_bank0_check_en))
		else $error("bank check enables not independent");

	a_ecc_together: assert property ( // see [RL9]
		SEC_ECC && B1_CHK_OK && cfg_loaded |-> secondary_bank0_check_en == secondary_bank1_check_en)
		else $error("ECC bank checks differ");

	a_check_legal: assert property ( // see [RL10]
		(!PRIM_CHK_OK |-> !primary_ram_check_en) and (!B1_CHK_OK |-> !secondary_bank1_check_en))
		else $error("check enabled without matching build");

	a_ext_err_write: assert property ( // see [RL11]
		sw_aux_wr && cfg_loaded && BANK1_OK
			|=> secondary_bank1_ext_err_en == $past(sw_bank1_ext_err_en)
			&& secondary_bank0_ext_err_en == $past(sw_bank0_ext_err_en))
		else $error("external error enable not written");

	a_rmw_legal: assert property ( // see [RL12]
		(!SEC_RMW_OK |-> !secondary_ram_rmw_en) and (!PRIM_RMW_OK |-> !primary_ram_rmw_en))
		else $error("rmw enabled with 32-bit ECC");

	a_sys_write: assert property ( // see [RL13]
		sw_sys_wr && cfg_loaded |=> exception_byte_order == $past(sw_byte_order)
			&& exception_instr_state == $past(sw_instr_state))
		else $error("system field write lost");

	a_primary_base_load: assert property ( // see [RL14]
		!rst && load |=> primary_local_ram_base == ($past(cfg_primary_base_sel)
			? PRIMARY_CFG_BASE : rcs_pkg::RCS_RAM_BASE_ZERO))
		else $error("primary base wrong after load");

	a_straps_ignored: assert property ( // see [RL15]
		cfg_loaded && !sw_sys_wr |=> $stable(vector_base) && $stable(exception_byte_order))
		else $error("field moved without a write");

	c_load_high_vec: cover property (load && cfg_vec_high);
	c_mask_refused: cover property (cfg_loaded && sw_sys_wr && sw_fiq_mask && fast_interrupt_nonmaskable);
	c_aux_write: cover property (cfg_loaded && sw_aux_wr && sw_bank0_check_en && !sw_bank1_check_en);
	c_strap_moved: cover property (cfg_strap_moved);

endmodule

// [verif/rcs_strap_model.sv]
// Integrator tie-off model that drives the strap inputs of the block.
`timescale 1ns/1ns

module rcs_strap_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [16:0] val,
	input  wire logic        flip,
	output logic      [16:0] straps
);
	// Straps follow the chosen tie-off only while reset is held, so they stand still at release.
	// A flip request inverts every strap after release, to show that late moves are ignored.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			straps <= val;
		end else if (flip) begin
			straps <= ~straps;
		end
	end
endmodule

// [verif/reset_config_straps_bench.sv]
// Self-checking bench for the reset configuration straps block.
`timescale 1ns/1ns

module reset_config_straps_bench;
	localparam logic [31:0] PB = 32'h0004_0000;
	localparam logic [31:0] SB = 32'h0080_0000;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        flip = 1'b0;
	logic [16:0] val = 17'h0;
	logic [16:0] st;
	logic [31:0] seed = 32'h59b4;
	logic        sw_sys_wr = 1'b0, sw_region_wr = 1'b0, sw_aux_wr = 1'b0;
	logic [13:0] sw = 14'h0;
	logic [31:0] swpb = 32'h0, swsb = 32'h0;
	logic [31:0] vector_base, primary_local_ram_base, secondary_local_ram_base;
	logic        pen, sen, bo, is, nm, mk_o, po, piu, ld_o, mv_o;
	logic        pc, b0c, b1c, pe, b0e, b1e, pr, sr;
	logic [113:0] eo;
	// Reference state: field bits indexed like the straps, plus bases and flags.
	logic [16:0] m = 17'h0;
	logic [31:0] mpb = 32'h0, msb = 32'h0;
	logic        mk = 1'b1, ld = 1'b0, mv = 1'b0;
	int          error_cnt = 0, total_checks = 0, cyc = 0;

	rcs_strap_model partner (.core_clk(core_clk), .rst(rst), .val(val), .flip(flip), .straps(st));

	rcs_top #(.PRIMARY_CFG_BASE(PB), .SECONDARY_CFG_BASE(SB)) uut (
		.core_clk(core_clk), .rst(rst), .cfg_vec_high(st[0]), .cfg_byte_order(st[1]),
		.cfg_instr_state(st[2]), .cfg_primary_en(st[3]), .cfg_primary_base_sel(st[4]),
		.cfg_secondary_en(st[5]), .cfg_secondary_base_sel(st[6]), .cfg_fiq_nonmaskable(st[7]),
		.cfg_parity_odd(st[8]), .cfg_primary_check(st[9]), .cfg_bank0_check(st[10]),
		.cfg_bank1_check(st[11]), .cfg_primary_ext_err(st[12]), .cfg_bank0_ext_err(st[13]),
		.cfg_bank1_ext_err(st[14]), .cfg_primary_rmw(st[15]), .cfg_secondary_rmw(st[16]),
		.sw_sys_wr(sw_sys_wr), .sw_vec_high(sw[0]), .sw_byte_order(sw[1]),
		.sw_instr_state(sw[2]), .sw_fiq_mask(sw[3]), .sw_region_wr(sw_region_wr),
		.sw_primary_en(sw[4]), .sw_primary_base(swpb), .sw_secondary_en(sw[5]),
		.sw_secondary_base(swsb), .sw_aux_wr(sw_aux_wr), .sw_primary_check_en(sw[6]),
		.sw_bank0_check_en(sw[7]), .sw_bank1_check_en(sw[8]), .sw_primary_ext_err_en(sw[9]),
		.sw_bank0_ext_err_en(sw[10]), .sw_bank1_ext_err_en(sw[11]),
		.sw_primary_rmw_en(sw[12]), .sw_secondary_rmw_en(sw[13]),
		.vector_base(vector_base), .exception_byte_order(bo), .exception_instr_state(is),
		.primary_local_ram_en(pen), .primary_local_ram_base(primary_local_ram_base),
		.secondary_local_ram_en(sen), .secondary_local_ram_base(secondary_local_ram_base),
		.fast_interrupt_nonmaskable(nm), .fast_interrupt_masked(mk_o), .parity_odd(po),
		.parity_in_use(piu), .primary_ram_check_en(pc), .secondary_bank0_check_en(b0c),
		.secondary_bank1_check_en(b1c), .primary_ram_ext_err_en(pe),
		.secondary_bank0_ext_err_en(b0e), .secondary_bank1_ext_err_en(b1e),
		.primary_ram_rmw_en(pr), .secondary_ram_rmw_en(sr), .cfg_loaded(ld_o),
		.cfg_strap_moved(mv_o)
	);

	// A second build with ECC on the secondary RAM and no primary checking, same stimulus.
	rcs_top #(.PRIMARY_CHECK(rcs_pkg::RCS_CHK_NONE), .SECONDARY_CHECK(rcs_pkg::RCS_CHK_ECC32),
		.PRIMARY_CFG_BASE(PB), .SECONDARY_CFG_BASE(SB)) uut_ecc (
		.core_clk(core_clk), .rst(rst), .cfg_vec_high(st[0]), .cfg_byte_order(st[1]),
		.cfg_instr_state(st[2]), .cfg_primary_en(st[3]), .cfg_primary_base_sel(st[4]),
		.cfg_secondary_en(st[5]), .cfg_secondary_base_sel(st[6]), .cfg_fiq_nonmaskable(st[7]),
		.cfg_parity_odd(st[8]), .cfg_primary_check(st[9]), .cfg_bank0_check(st[10]),
		.cfg_bank1_check(st[11]), .cfg_primary_ext_err(st[12]), .cfg_bank0_ext_err(st[13]),
		.cfg_bank1_ext_err(st[14]), .cfg_primary_rmw(st[15]), .cfg_secondary_rmw(st[16]),
		.sw_sys_wr(sw_sys_wr), .sw_vec_high(sw[0]), .sw_byte_order(sw[1]),
		.sw_instr_state(sw[2]), .sw_fiq_mask(sw[3]), .sw_region_wr(sw_region_wr),
		.sw_primary_en(sw[4]), .sw_primary_base(swpb), .sw_secondary_en(sw[5]),
		.sw_secondary_base(swsb), .sw_aux_wr(sw_aux_wr), .sw_primary_check_en(sw[6]),
		.sw_bank0_check_en(sw[7]), .sw_bank1_check_en(sw[8]), .sw_primary_ext_err_en(sw[9]),
		.sw_bank0_ext_err_en(sw[10]), .sw_bank1_ext_err_en(sw[11]),
		.sw_primary_rmw_en(sw[12]), .sw_secondary_rmw_en(sw[13]),
		.vector_base(eo[113:82]), .primary_local_ram_base(eo[81:50]),
		.secondary_local_ram_base(eo[49:18]), .primary_local_ram_en(eo[17]),
		.secondary_local_ram_en(eo[16]), .exception_instr_state(eo[15]),
		.exception_byte_order(eo[14]), .fast_interrupt_nonmaskable(eo[13]),
		.fast_interrupt_masked(eo[12]), .parity_odd(eo[11]),
		.secondary_bank1_check_en(eo[10]), .secondary_bank0_check_en(eo[9]),
		.primary_ram_check_en(eo[8]), .secondary_bank1_ext_err_en(eo[7]),
		.secondary_bank0_ext_err_en(eo[6]), .primary_ram_ext_err_en(eo[5]),
		.secondary_ram_rmw_en(eo[4]), .primary_ram_rmw_en(eo[3]), .parity_in_use(eo[2]),
		.cfg_loaded(eo[1]), .cfg_strap_moved(eo[0])
	);

	// Free-running core clock at 125 MHz.
	always #4 core_clk = ~core_clk;

	// Bases are compared even while their RAM is disabled, since the field is still held.
	function automatic logic [113:0] obs();
		return {vector_base, primary_local_ram_base,
			secondary_local_ram_base, pen, sen, is, bo, nm, mk_o, po,
			b1c, b0c, pc, b1e, b0e, pe, sr, pr, piu, ld_o, mv_o};
	endfunction

	// Expected outputs from the reference state; every RAM exists and uses parity here.
	function automatic logic [113:0] expv();
		return {m[0] ? rcs_pkg::RCS_VEC_HIGH_BASE : rcs_pkg::RCS_VEC_LOW_BASE,
			mpb, msb, m[3], m[5], m[2], m[1], m[7], mk, m[8],
			m[11], m[10], m[9], m[14], m[13], m[12], m[16], m[15], 1'b1, ld, mv};
	endfunction

	// ECC build: bank 1 follows bank 0, no primary check, no secondary rmw, no parity in use.
	function automatic logic [113:0] expe();
		logic [113:0] e;
		e = expv();
		e[10] = m[10];
		{e[8], e[4], e[2]} = 3'h0;
		return e;
	endfunction

	// Sixteen steps of the shift register give each draw fresh bits.
	function automatic logic [31:0] nxt(input logic [31:0] x);
		for (int k = 0; k < 16; k++) begin
			x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
		end
		return x;
	endfunction

	task automatic chk(input logic [113:0] seen, input logic [113:0] want);
		total_checks++;
		if (seen !== want) begin
			error_cnt++;
			$display("unexpected at %0t: outputs %h, wanted %h", $time, seen, want);
		end
	endtask

	task automatic end_sim();
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// One software write with random strobe groups, then the reference follows.
	task automatic wr();
		logic [2:0]  g;
		logic [13:0] v;
		logic [31:0] a;
		logic [31:0] b;
		@(posedge core_clk);
		seed = nxt(seed);
		g = seed[2:0];
		v = seed[16:3];
		a = nxt(seed);
		b = nxt(a);
		seed = b;
		{sw_aux_wr, sw_region_wr, sw_sys_wr} <= g;
		sw <= v;
		swpb <= a;
		swsb <= b;
		@(posedge core_clk);
		{sw_aux_wr, sw_region_wr, sw_sys_wr} <= 3'h0;
		#1;
		if (g[0]) begin
			m[2:0] = v[2:0];
			mk = v[3] & ~m[7];
		end
		if (g[1]) begin
			m[3] = v[4];
			m[5] = v[5];
			mpb = a;
			msb = b;
		end
		if (g[2]) begin
			m[16:9] = v[13:6];
		end
		chk(obs(), expv());
		chk(eo, expe());
	endtask

	// A hang counts as a mismatch and ends the run.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			end_sim();
		end
	end

	// Each pass: reset with random straps, load, software writes, then late strap moves.
	initial begin
		seed = nxt(seed);
		val = seed[16:0];
		for (int i = 0; i < 8; i++) begin
			repeat (5) @(posedge core_clk);
			#1 chk(obs(), expv());
			chk(eo, expe());
			@(posedge core_clk);
			rst <= 1'b0;
			sw_sys_wr <= 1'b1;
			sw <= ~val[13:0];
			@(posedge core_clk);
			sw_sys_wr <= 1'b0;
			#1;
			m = val;
			mpb = val[4] ? PB : 32'h0;
			msb = val[6] ? SB : 32'h0;
			mk = ~val[7];
			ld = 1'b1;
			chk(obs(), expv());
			chk(eo, expe());
			repeat (6) wr();
			@(posedge core_clk);
			flip <= 1'b1;
			@(posedge core_clk);
			flip <= 1'b0;
			@(posedge core_clk);
			#1 mv = 1'b1;
			chk(obs(), expv());
			chk(eo, expe());
			@(posedge core_clk);
			seed = nxt(seed);
			val <= seed[16:0];
			rst <= 1'b1;
			m = 17'h0;
			{mpb, msb} = 64'h0;
			{mk, ld, mv} = 3'h4;
		end
		end_sim();
	end
endmodule
